// *** csf_alu.sv ***
// Shared constants, opcode type and the flag-producing ALU.
`timescale 1ns/100ps
`default_nettype none

package csf_pkg;

    localparam int DATA_W      = 8;
    localparam int NIBBLE_W    = 4;
    localparam int REG_ADDR_W  = 8;
    localparam int BANK_OFS_W  = 7;
    localparam int PHYS_ADDR_W = 9;
    localparam int BIT_SEL_W   = 3;

    localparam logic [REG_ADDR_W-1:0] STATUS_ADDR = 8'h03;

    localparam int CARRY_BIT  = 0;
    localparam int NIBBLE_BIT = 1;
    localparam int ZERO_BIT   = 2;
    localparam int HALT_BIT   = 3;
    localparam int EXPIRY_BIT = 4;
    localparam int DBANK_LO   = 5;
    localparam int DBANK_HI   = 6;
    localparam int IBANK_BIT  = 7;

    localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;

    typedef enum logic [13:0] {
        OP_PLUS            = 14'h0001,
        OP_MINUS           = 14'h0002,
        OP_AND             = 14'h0004,
        OP_OR              = 14'h0008,
        OP_XOR             = 14'h0010,
        OP_FILE_ZERO       = 14'h0020,
        OP_ACCUM_STORE     = 14'h0040,
        OP_BIT_ZERO        = 14'h0080,
        OP_BIT_ONE         = 14'h0100,
        OP_NIBBLE_EXCHANGE = 14'h0200,
        OP_SHIFT_LEFT      = 14'h0400,
        OP_SHIFT_RIGHT     = 14'h0800,
        OP_WATCHDOG_KICK   = 14'h1000,
        OP_HALT            = 14'h2000
    } csf_op_t;

    function automatic logic op_sets_zero(input csf_op_t op);
        return (op == OP_PLUS) || (op == OP_MINUS) || (op == OP_AND) ||
               (op == OP_OR) || (op == OP_XOR) || (op == OP_FILE_ZERO);
    endfunction

    function automatic logic op_sets_nibble(input csf_op_t op);
        return (op == OP_PLUS) || (op == OP_MINUS);
    endfunction

    function automatic logic op_sets_carry(input csf_op_t op);
        return (op == OP_PLUS) || (op == OP_MINUS) ||
               (op == OP_SHIFT_LEFT) || (op == OP_SHIFT_RIGHT);
    endfunction

    function automatic logic op_writes_result(input csf_op_t op);
        return (op != OP_WATCHDOG_KICK) && (op != OP_HALT);
    endfunction

endpackage

module csf_alu
    import csf_pkg::*;
(
    input  wire csf_pkg::csf_op_t               op_in,
    input  wire logic [csf_pkg::DATA_W-1:0]     a_in,
    input  wire logic [csf_pkg::DATA_W-1:0]     b_in,
    input  wire logic [csf_pkg::BIT_SEL_W-1:0]  bit_sel_in,
    input  wire logic                           carry_in,
    output logic      [csf_pkg::DATA_W-1:0]     result_out,
    output logic                                zero_out,
    output logic                                nibble_out,
    output logic                                carry_out
);

    import csf_pkg::*;

    logic [DATA_W-1:0]   b_eff;
    logic                cin;
    logic [DATA_W:0]     sum;
    logic [NIBBLE_W:0]   nib_sum;
    logic [DATA_W-1:0]   bit_mask;

    always_comb begin
        b_eff    = (op_in == OP_MINUS) ? ~b_in : b_in;
        cin      = (op_in == OP_MINUS);
        sum      = {1'b0, a_in} + {1'b0, b_eff} + {{DATA_W{1'b0}}, cin};
        nib_sum  = {1'b0, a_in[NIBBLE_W-1:0]} + {1'b0, b_eff[NIBBLE_W-1:0]}
                 + {{NIBBLE_W{1'b0}}, cin};
        bit_mask = 8'h01 << bit_sel_in;
        carry_out = sum[DATA_W];
        case (op_in)
            OP_PLUS,
            OP_MINUS:           result_out = sum[DATA_W-1:0];
            OP_AND:             result_out = a_in & b_in;
            OP_OR:              result_out = a_in | b_in;
            OP_XOR:             result_out = a_in ^ b_in;
            OP_FILE_ZERO:       result_out = 8'h00;
            OP_ACCUM_STORE:     result_out = b_in;
            OP_BIT_ZERO:        result_out = a_in & ~bit_mask;
            OP_BIT_ONE:         result_out = a_in | bit_mask;
            OP_NIBBLE_EXCHANGE: result_out = {a_in[3:0], a_in[7:4]};
            OP_SHIFT_LEFT: begin
                result_out = {a_in[DATA_W-2:0], carry_in};
                carry_out  = a_in[DATA_W-1];
            end
            OP_SHIFT_RIGHT: begin
                result_out = {carry_in, a_in[DATA_W-1:1]};
                carry_out  = a_in[0];
            end
            default:            result_out = a_in;
        endcase
        nibble_out = nib_sum[NIBBLE_W];
        zero_out   = (result_out == 8'h00);
    end

endmodule

`default_nettype wire

// *** csf_core_model.sv ***
// Behavioural model of the instruction unit that drives the status block.
`timescale 1ns/100ps
`default_nettype none

module csf_core_model
    import csf_pkg::*;
(
    input  wire logic                           clk_in,
    output var logic                            instr_valid_out,
    output var csf_pkg::csf_op_t                instr_op_out,
    output var logic [csf_pkg::DATA_W-1:0]      operand_a_out,
    output var logic [csf_pkg::DATA_W-1:0]      operand_b_out,
    output var logic [csf_pkg::BIT_SEL_W-1:0]   bit_sel_out,
    output var logic                            dest_status_out,
    output var logic                            watchdog_timeout_out,
    output var logic [csf_pkg::BANK_OFS_W-1:0]  direct_offset_out,
    output var logic [csf_pkg::DATA_W-1:0]      indirect_ptr_out
);
    import csf_pkg::*;

    initial begin
        instr_valid_out = 1'b0;
        instr_op_out = OP_ACCUM_STORE;
        operand_a_out = 8'h00;
        operand_b_out = 8'h00;
        bit_sel_out = 3'h0;
        dest_status_out = 1'b0;
        watchdog_timeout_out = 1'b0;
        direct_offset_out = 7'h00;
        indirect_ptr_out = 8'h00;
    end

    // Presents one instruction; status flags are altered by flag ops whatever the destination.
    task automatic issue(input csf_op_t op, input logic [7:0] a,
                         input logic [7:0] b, input logic [2:0] bs,
                         input logic dst);
        @(posedge clk_in);
        instr_valid_out <= 1'b1;
        instr_op_out <= op;
        operand_a_out <= a;
        operand_b_out <= b;
        bit_sel_out <= bs;
        dest_status_out <= dst;
    endtask

    // Idle cycles scramble the operands so stale values are never trusted.
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk_in);
            instr_valid_out <= 1'b0;
            dest_status_out <= 1'b0;
            operand_a_out <= ~operand_a_out;
            operand_b_out <= ~operand_b_out;
        end
    endtask

    task automatic timeout();
        @(posedge clk_in);
        watchdog_timeout_out <= 1'b1;
        @(posedge clk_in);
        watchdog_timeout_out <= 1'b0;
    endtask

    task automatic set_addr(input logic [6:0] ofs, input logic [7:0] ptr);
        @(posedge clk_in);
        direct_offset_out <= ofs;
        indirect_ptr_out <= ptr;
    endtask
endmodule
`default_nettype wire

// *** csf_status_reg.sv ***
// Core status flag register with flag update, bank steering and bus port.
//
// Notes on behaviour
// - The status register may be the destination of any instruction.
// - A flag-affecting instruction aimed at it writes flags to bits 2 to 0 and data to bits 7 to 5.
// - Software cannot write the expiry and halt flags.
// - Clearing the register clears the bank bits and sets zero.
// - On subtraction carry and nibble carry mean no borrow when one.
// - Bit 7 steers indirect access to banks two and three when one.
// - Bits 6 to 5 choose the bank for direct access.
// - The active-low expiry flag is set by power-up, kick or halt.
// - The active-low halt flag is set by power-up or kick, cleared by halt.
// - The zero flag shows whether an add, subtract, logic or clear result is zero.
// - Add and subtract set nibble carry from the fourth bit carry.
// - Add and subtract set carry from the top bit carry.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the bit shifted out.
//
// The strobed register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

module csf_status_reg
    import csf_pkg::*;
#(
    parameter int ADDR_W = csf_pkg::REG_ADDR_W
)
(
    input  wire logic                              clk_in,
    input  wire logic                              resetn_in,
    input  wire logic [ADDR_W-1:0]                 reg_addr_in,
    input  wire logic [csf_pkg::DATA_W-1:0]        reg_wdata_in,
    input  wire logic                              reg_wr_in,
    input  wire logic                              reg_rd_in,
    output logic      [csf_pkg::DATA_W-1:0]        reg_rdata_out,
    input  wire logic                              instr_valid_in,
    input  wire csf_pkg::csf_op_t                  instr_op_in,
    input  wire logic [csf_pkg::DATA_W-1:0]        operand_a_in,
    input  wire logic [csf_pkg::DATA_W-1:0]        operand_b_in,
    input  wire logic [csf_pkg::BIT_SEL_W-1:0]     bit_sel_in,
    input  wire logic                              dest_status_in,
    input  wire logic                              watchdog_timeout_in,
    input  wire logic [csf_pkg::BANK_OFS_W-1:0]    direct_offset_in,
    input  wire logic [csf_pkg::DATA_W-1:0]        indirect_ptr_in,
    output logic      [csf_pkg::DATA_W-1:0]        status_out,
    output logic      [csf_pkg::DATA_W-1:0]        result_out,
    output logic                                   result_valid_out,
    output logic      [csf_pkg::PHYS_ADDR_W-1:0]   direct_addr_out,
    output logic      [csf_pkg::PHYS_ADDR_W-1:0]   indirect_addr_out
);

    import csf_pkg::*;

    logic [DATA_W-1:0]  status_reg;
    logic [DATA_W-1:0]  status_next;
    logic [DATA_W-1:0]  alu_result;
    logic               alu_zero;
    logic               alu_nibble;
    logic               alu_carry;
    logic               status_sel;
    logic               any_flag;
    logic               exec_write;

    csf_alu u_alu (
        .op_in      (instr_op_in),
        .a_in       (operand_a_in),
        .b_in       (operand_b_in),
        .bit_sel_in (bit_sel_in),
        .carry_in   (status_reg[CARRY_BIT]),
        .result_out (alu_result),
        .zero_out   (alu_zero),
        .nibble_out (alu_nibble),
        .carry_out  (alu_carry)
    );

    always_comb begin
        status_sel = 1'b0;
        if (reg_addr_in == STATUS_ADDR) begin
            status_sel = 1'b1;
        end
    end

    always_comb begin
        any_flag   = op_sets_zero(instr_op_in) ||
                     op_sets_nibble(instr_op_in) ||
                     op_sets_carry(instr_op_in);
        exec_write = instr_valid_in && op_writes_result(instr_op_in);
    end

    always_comb begin
        status_next = status_reg;
        if (instr_valid_in) begin
            if (exec_write && dest_status_in) begin
                status_next[IBANK_BIT:DBANK_LO] =
                    alu_result[IBANK_BIT:DBANK_LO];
                if (!any_flag) begin
                    status_next[ZERO_BIT:CARRY_BIT] =
                        alu_result[ZERO_BIT:CARRY_BIT];
                end
            end
            if (op_sets_zero(instr_op_in)) begin
                status_next[ZERO_BIT] = alu_zero;
            end
            if (op_sets_nibble(instr_op_in)) begin
                status_next[NIBBLE_BIT] = alu_nibble;
            end
            if (op_sets_carry(instr_op_in)) begin
                status_next[CARRY_BIT] = alu_carry;
            end
            if (instr_op_in == OP_WATCHDOG_KICK) begin
                status_next[EXPIRY_BIT] = 1'b1;
                status_next[HALT_BIT]   = 1'b1;
            end
            if (instr_op_in == OP_HALT) begin
                status_next[EXPIRY_BIT] = 1'b1;
                status_next[HALT_BIT]   = 1'b0;
            end
        end else if (reg_wr_in && status_sel) begin
            status_next[IBANK_BIT:DBANK_LO] =
                reg_wdata_in[IBANK_BIT:DBANK_LO];
            status_next[ZERO_BIT:CARRY_BIT] =
                reg_wdata_in[ZERO_BIT:CARRY_BIT];
        end
        if (watchdog_timeout_in) begin
            status_next[EXPIRY_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            status_reg <= STATUS_RST;
        end else begin
            status_reg <= status_next;
        end
    end

    always_comb begin
        status_out = status_reg;
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            result_out       <= 8'h00;
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= exec_write;
            if (exec_write) begin
                result_out <= alu_result;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in && status_sel) begin
            reg_rdata_out <= status_reg;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            direct_addr_out   <= 9'h000;
            indirect_addr_out <= 9'h000;
        end else begin
            direct_addr_out   <= {status_reg[DBANK_HI:DBANK_LO],
                                  direct_offset_in};
            indirect_addr_out <= {status_reg[IBANK_BIT],
                                  indirect_ptr_in};
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    sequence s_exec(csf_op_t op);
        instr_valid_in && instr_op_in == op;
    endsequence

    sequence s_to_status(csf_op_t op);
        s_exec(op) ##0 dest_status_in;
    endsequence

    sequence s_elsewhere(csf_op_t op);
        s_exec(op) ##0 !dest_status_in;
    endsequence

    a_store_to_status: assert property (
        s_to_status(OP_ACCUM_STORE) |=>
            status_reg[7:5] == $past(operand_b_in[7:5]) &&
            status_reg[2:0] == $past(operand_b_in[2:0]))
        else $error("Store to status did not land.");

    a_flag_write_block: assert property (
        s_to_status(OP_PLUS) |=>
            status_reg[ZERO_BIT] == (result_out == 8'h00) &&
            status_reg[NIBBLE_BIT] ==
                ({1'b0, $past(operand_a_in[3:0])} +
                 {1'b0, $past(operand_b_in[3:0])} > 5'h0F) &&
            status_reg[CARRY_BIT] ==
                ({1'b0, $past(operand_a_in)} +
                 {1'b0, $past(operand_b_in)} > 9'h0FF))
        else $error("Data write reached the ALU flags.");

    a_bus_guard_flags: assert property (
        reg_wr_in && status_sel && !instr_valid_in &&
        !watchdog_timeout_in |=> $stable(status_reg[4:3]))
        else $error("Bus write changed expiry or halt flag.");

    a_clear_status: assert property (
        s_to_status(OP_FILE_ZERO) ##0 !watchdog_timeout_in |=>
            status_reg[7:5] == 3'b000 && status_reg[ZERO_BIT] &&
            status_reg[4:3] == $past(status_reg[4:3]) &&
            status_reg[1:0] == $past(status_reg[1:0]))
        else $error("Clearing status gave a wrong pattern.");

    a_sub_no_borrow: assert property (
        s_elsewhere(OP_MINUS) |=>
            status_reg[CARRY_BIT] ==
                ($past(operand_a_in) >= $past(operand_b_in)) &&
            status_reg[NIBBLE_BIT] ==
                ($past(operand_a_in[3:0]) >= $past(operand_b_in[3:0])))
        else $error("Borrow sense of subtraction is wrong.");

    a_indirect_steer: assert property (
        1'b1 |=> indirect_addr_out ==
            {$past(status_reg[IBANK_BIT]), $past(indirect_ptr_in)})
        else $error("Indirect bank steering is wrong.");

    a_direct_steer: assert property (
        1'b1 |=> direct_addr_out[8:7] == $past(status_reg[6:5]) &&
                 direct_addr_out[6:0] == $past(direct_offset_in))
        else $error("Direct bank steering is wrong.");

    a_timeout_clears: assert property (
        watchdog_timeout_in |=> !status_reg[EXPIRY_BIT])
        else $error("Timeout left the expiry flag high.");

    a_halt_flags: assert property (
        s_exec(OP_HALT) ##0 !watchdog_timeout_in |=>
            status_reg[4:3] == 2'b10)
        else $error("Halt did not set the expected flags.");

    a_kick_flags: assert property (
        s_exec(OP_WATCHDOG_KICK) ##0 !watchdog_timeout_in |=>
            status_reg[4:3] == 2'b11)
        else $error("Kick did not set both flags.");

    a_zero_logic: assert property (
        s_elsewhere(OP_AND) |=> status_reg[ZERO_BIT] ==
            (($past(operand_a_in) & $past(operand_b_in)) == 8'h00))
        else $error("Zero flag wrong after logic operation.");

    a_add_nibble: assert property (
        s_elsewhere(OP_PLUS) |=> status_reg[NIBBLE_BIT] ==
            ({1'b0, $past(operand_a_in[3:0])} +
             {1'b0, $past(operand_b_in[3:0])} > 5'h0F))
        else $error("Nibble carry wrong after add.");

    a_add_carry: assert property (
        s_elsewhere(OP_PLUS) |=> status_reg[CARRY_BIT] ==
            ({1'b0, $past(operand_a_in)} +
             {1'b0, $past(operand_b_in)} > 9'h0FF))
        else $error("Carry wrong after add.");

    a_sub_twos: assert property (
        s_elsewhere(OP_MINUS) |=> result_valid_out &&
            result_out == 8'($past(operand_a_in) - $past(operand_b_in)))
        else $error("Subtraction result is wrong.");

    a_rotate_left: assert property (
        s_elsewhere(OP_SHIFT_LEFT) |=>
            status_reg[CARRY_BIT] == $past(operand_a_in[7]) &&
            result_out[0] == $past(status_reg[CARRY_BIT]))
        else $error("Left rotate carry is wrong.");

    a_rotate_right: assert property (
        s_elsewhere(OP_SHIFT_RIGHT) |=>
            status_reg[CARRY_BIT] == $past(operand_a_in[0]) &&
            result_out[7] == $past(status_reg[CARRY_BIT]))
        else $error("Right rotate carry is wrong.");

    a_read_back: assert property (
        reg_rd_in && status_sel |=> reg_rdata_out == $past(status_reg))
        else $error("Bus read does not show the status.");

    a_read_idle_zero: assert property (
        !(reg_rd_in && status_sel) |=> reg_rdata_out == 8'h00)
        else $error("Read data did not return to zero.");

    a_bank_hold: assert property (
        instr_valid_in && !dest_status_in |=> $stable(status_reg[7:5]))
        else $error("Bank bits changed without a status destination.");

    a_reset_value: assert property (
        disable iff (1'b0)
        !resetn_in |=> status_reg[7:3] == 5'b00011)
        else $error("Reset left a wrong bank or cause pattern.");

endmodule

`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the core status flag register.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import csf_pkg::*;

    logic       clk_in = 1'b0;
    logic       resetn_in = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] rdata, status, result;
    logic       rvalid, iv, dst, wd_timeout;
    logic [8:0] daddr, iaddr;
    csf_op_t    op;
    logic [7:0] opa, opb, ptr;
    logic [2:0] bsel;
    logic [6:0] ofs;
    logic [7:0] st = 8'h18;
    int         num_errors = 0;
    int         check_count = 0;
    csf_op_t    ops [16] = '{OP_PLUS, OP_PLUS, OP_MINUS, OP_MINUS, OP_MINUS,
        OP_MINUS, OP_AND, OP_OR, OP_XOR, OP_SHIFT_LEFT, OP_SHIFT_RIGHT,
        OP_SHIFT_RIGHT, OP_NIBBLE_EXCHANGE, OP_BIT_ZERO, OP_BIT_ONE,
        OP_ACCUM_STORE};
    logic [7:0] va [16] = '{8'h0F, 8'hFF, 8'h05, 8'h03, 8'h10, 8'h00,
        8'hF0, 8'h00, 8'h5A, 8'h81, 8'h01, 8'h02, 8'h3C, 8'hFF, 8'h00, 8'h00};
    logic [7:0] vb [16] = '{8'h01, 8'h01, 8'h03, 8'h05, 8'h01, 8'h00,
        8'h0F, 8'h40, 8'h5A, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h77};

    always #4 clk_in = ~clk_in;

    csf_status_reg i_csf_status_reg (
        .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .instr_valid_in(iv), .instr_op_in(op),
        .operand_a_in(opa), .operand_b_in(opb), .bit_sel_in(bsel),
        .dest_status_in(dst), .watchdog_timeout_in(wd_timeout),
        .direct_offset_in(ofs), .indirect_ptr_in(ptr), .status_out(status),
        .result_out(result), .result_valid_out(rvalid),
        .direct_addr_out(daddr), .indirect_addr_out(iaddr));

    csf_core_model i_csf_core_model (
        .clk_in(clk_in), .instr_valid_out(iv), .instr_op_out(op),
        .operand_a_out(opa), .operand_b_out(opb), .bit_sel_out(bsel),
        .dest_status_out(dst), .watchdog_timeout_out(wd_timeout),
        .direct_offset_out(ofs), .indirect_ptr_out(ptr));

    task automatic report_and_stop();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        check_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_in);
        reg_wr <= 1'b0;
        #1;
        if (a == STATUS_ADDR) begin
            st = {d[7:5], st[4:3], d[2:0]};
        end
        chk("status", {1'b0, st}, {1'b0, status});
    endtask

    task automatic bus_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", {1'b0, e}, {1'b0, rdata});
    endtask

    // Runs one instruction and compares against a locally computed result.
    task automatic run(input csf_op_t o, input logic [7:0] a,
                       input logic [7:0] b, input logic [2:0] bs,
                       input logic d);
        logic [8:0] s;
        logic [4:0] n;
        logic [7:0] r;
        logic       c, dc, z, wr, fl;
        c = st[0];
        dc = st[1];
        z = st[2];
        r = 8'h00;
        s = 9'h000;
        n = 5'h00;
        wr = (o != OP_WATCHDOG_KICK) && (o != OP_HALT);
        fl = 1'b1;
        case (o)
            OP_PLUS: begin
                s = {1'b0, a} + {1'b0, b};
                n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
            end
            OP_MINUS: begin
                s = {1'b0, a} + {1'b0, ~b} + 9'h001;
                n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
            end
            OP_AND: r = a & b;
            OP_OR: r = a | b;
            OP_XOR: r = a ^ b;
            OP_FILE_ZERO: r = 8'h00;
            OP_SHIFT_LEFT: begin
                r = {a[6:0], c};
                c = a[7];
            end
            OP_SHIFT_RIGHT: begin
                r = {c, a[7:1]};
                c = a[0];
            end
            OP_ACCUM_STORE: fl = 1'b0;
            OP_BIT_ZERO: fl = 1'b0;
            OP_BIT_ONE: fl = 1'b0;
            OP_NIBBLE_EXCHANGE: fl = 1'b0;
            default: fl = 1'b0;
        endcase
        if (o == OP_ACCUM_STORE) r = b;
        if (o == OP_BIT_ZERO) r = a & ~(8'h01 << bs);
        if (o == OP_BIT_ONE) r = a | (8'h01 << bs);
        if (o == OP_NIBBLE_EXCHANGE) r = {a[3:0], a[7:4]};
        if (o == OP_PLUS || o == OP_MINUS) begin
            r = s[7:0];
            c = s[8];
            dc = n[4];
        end
        if (fl && o != OP_SHIFT_LEFT && o != OP_SHIFT_RIGHT) z = (r == 8'h00);
        if (d && wr) st[7:5] = r[7:5];
        st[2:0] = (d && wr && !fl) ? r[2:0] : {z, dc, c};
        if (o == OP_WATCHDOG_KICK) st[4:3] = 2'b11;
        if (o == OP_HALT) st[4:3] = 2'b10;
        i_csf_core_model.issue(o, a, b, bs, d);
        i_csf_core_model.idle(1);
        #1;
        chk("status", {1'b0, st}, {1'b0, status});
        chk("result_valid", {8'h00, wr}, {8'h00, rvalid});
        if (wr) chk("result", {1'b0, r}, {1'b0, result});
    endtask

    initial begin
        repeat (2000) @(posedge clk_in);
        num_errors++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(posedge clk_in);
        resetn_in <= 1'b1;
        #1;
        chk("status", 9'h018, {1'b0, status});
        bus_rd(STATUS_ADDR, 8'h18);
        bus_wr(STATUS_ADDR, 8'hE7);
        bus_wr(8'h04, 8'h00);
        bus_rd(8'h04, 8'h00);
        bus_wr(STATUS_ADDR, 8'h00);
        $display("test register access done");
        i_csf_core_model.set_addr(7'h55, 8'hA5);
        for (int i = 0; i < 4; i++) begin
            bus_wr(STATUS_ADDR, {i[0], i[1:0], 5'h00});
            @(posedge clk_in);
            #1;
            chk("direct_addr", {i[1:0], 7'h55}, daddr);
            chk("indirect_addr", {i[0], 8'hA5}, iaddr);
        end
        $display("test bank steering done");
        for (int i = 0; i < 16; i++) begin
            run(ops[i], va[i], vb[i], i[2:0], 1'b0);
            i_csf_core_model.idle(i % 3);
        end
        $display("test flag logic done");
        bus_wr(STATUS_ADDR, 8'h63);
        run(OP_PLUS, 8'hFF, 8'hE5, 3'h0, 1'b1);
        run(OP_FILE_ZERO, 8'h00, 8'h00, 3'h0, 1'b1);
        run(OP_BIT_ONE, st, 8'h00, 3'h6, 1'b1);
        run(OP_ACCUM_STORE, 8'h00, 8'h03, 3'h0, 1'b1);
        $display("test status destination done");
        run(OP_HALT, 8'h00, 8'h00, 3'h0, 1'b0);
        i_csf_core_model.timeout();
        #1;
        st[4] = 1'b0;
        chk("status", {1'b0, st}, {1'b0, status});
        bus_rd(STATUS_ADDR, st);
        run(OP_WATCHDOG_KICK, 8'h00, 8'h00, 3'h0, 1'b0);
        $display("test reset cause flags done");
        report_and_stop();
    end
endmodule
`default_nettype wire
